// ==== verilog/jid_defines.svh ====
// Constants for the test-port instruction decoder: opcodes, widths, fields
`ifndef JID_DEFINES_SVH
`define JID_DEFINES_SVH

// Instruction register
`define JID_IR_W 5
`define JID_IR_CAPTURE 5'h01

// Opcodes
`define JID_OP_DEVICE_IDENTITY_WORD 5'h00
`define JID_OP_BOARD_TAG_WORD 5'h03
`define JID_OP_ADDR_LOAD 5'h04
`define JID_OP_MEM_FETCH 5'h05
`define JID_OP_MEM_STORE 5'h06
`define JID_OP_RESTART 5'h07
`define JID_OP_SNAPSHOT 5'h08
`define JID_OP_EXT_ON 5'h09
`define JID_OP_EXT_OFF 5'h0a
`define JID_OP_NVM_ON 5'h0b
`define JID_OP_NVM_OFF 5'h0c
`define JID_OP_BYPASS 5'h1f

// Data path selection codes
`define JID_SEL_BYPASS 2'h0
`define JID_SEL_WORD 2'h1
`define JID_SEL_BYTE 2'h2

// Data widths
`define JID_WORD_W 32
`define JID_BYTE_W 8
`define JID_SADDR_W 7
`define JID_FLOG_W 2

// Identity and user word fields
`define JID_ID_FIXED 1'h1
`define JID_USER_PAD_W 17

// Synchroniser width, one bit per synchronised pin
`define JID_SYNC_W 3

`endif

// ==== verilog/jid_pkg.sv ====
// Types for the test-port instruction decoder
`default_nettype none

package jid_pkg;

	// Test port controller states, one-hot
	typedef enum logic [15:0] {
		JID_TAP_RESET = 16'h0001,
		JID_TAP_IDLE = 16'h0002,
		JID_SEL_DR = 16'h0004,
		JID_CAP_DR = 16'h0008,
		JID_SHF_DR = 16'h0010,
		JID_EX1_DR = 16'h0020,
		JID_PAU_DR = 16'h0040,
		JID_EX2_DR = 16'h0080,
		JID_UPD_DR = 16'h0100,
		JID_SEL_IR = 16'h0200,
		JID_CAP_IR = 16'h0400,
		JID_SHF_IR = 16'h0800,
		JID_EX1_IR = 16'h1000,
		JID_PAU_IR = 16'h2000,
		JID_EX2_IR = 16'h4000,
		JID_UPD_IR = 16'h8000
	} jid_tap_state_t;

endpackage

`default_nettype wire

// ==== verilog/jid_decoder.sv ====
// Serial test port: instruction register, decoder and data registers
//
// How it works
// - Five-bit instruction register: a shift stage plus a latched current instruction.
// - In shift-IR the shift stage sits between data in and out, shifting per rising edge.
// - Leaving exit1/exit2-IR into update-IR, the falling edge latches the instruction.
// - Opcode 1Fh routes data in to out through a one-bit bypass register.
// - Opcode 00h selects the identity register, loaded at capture-DR, shifted out.
// - In test-logic-reset the identification opcode is forced into the instruction.
// - Identity word: fixed 1, 11-bit maker, 16-bit part, 4-bit version.
// - Opcode 03h selects a 32-bit user-code register loaded at capture-DR.
// - User word: firmware tag byte low, slave address above, zeros on top.
// - Opcode 04h shifts an 8-bit address register that sets the memory pointer.
// - Opcode 05h shifts an 8-bit read register holding the byte at the pointer.
// - Opcode 06h shifts an 8-bit write register supplying the byte to store.
// - Latching opcode 07h restarts the device at once.
// - Opcode 08h triggers a fault log using the fault log control selection.
// - Opcode 09h enables the extended page, 0Ah disables it.
// - Opcode 0Bh maps every address to non-volatile memory, 0Ch undoes it.
// - Five rising clock edges with mode select high reach test-logic-reset.
// - Update-DR latches the shifted data on the falling edge, never while shifting.
`timescale 1ns/10ps
`default_nettype none
`include "jid_defines.svh"

module jid_decoder #(
	parameter logic [10:0] MAKER_ID = 11'h2a5, // Arbitrary value
	parameter logic [15:0] PART_ID = 16'h1234, // Arbitrary value
	parameter logic [3:0] VERSION_ID = 4'h2 // Arbitrary value
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Serial test pins
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// Device state used by the data registers and the fault log action
	input wire logic [`JID_BYTE_W-1:0] firmware_tag_i,
	input wire logic [`JID_SADDR_W-1:0] slave_addr_i,
	input wire logic [`JID_BYTE_W-1:0] mem_rdata_i,
	input wire logic [`JID_FLOG_W-1:0] fault_log_ctrl_i,
	// Current instruction
	output logic [`JID_IR_W-1:0] instr_o,
	// Memory access
	output logic [`JID_BYTE_W-1:0] mem_addr_o,
	output logic mem_addr_load_o,
	output logic mem_read_o,
	output logic [`JID_BYTE_W-1:0] mem_wdata_o,
	output logic mem_write_o,
	// Device actions
	output logic soft_restart_o,
	output logic fault_snapshot_o,
	output logic [`JID_FLOG_W-1:0] fault_sel_o,
	output logic ext_page_o,
	output logic nvm_page_o
);

	////////////////////////////////////////////////////////////////////
	// Functions

	// Next controller state from the mode select level
	function automatic jid_pkg::jid_tap_state_t tap_next(
		input jid_pkg::jid_tap_state_t st,
		input logic tms
	);
		case (st)
			jid_pkg::JID_TAP_RESET: tap_next = tms ? jid_pkg::JID_TAP_RESET : jid_pkg::JID_TAP_IDLE;
			jid_pkg::JID_TAP_IDLE: tap_next = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_TAP_IDLE;
			jid_pkg::JID_SEL_DR: tap_next = tms ? jid_pkg::JID_SEL_IR : jid_pkg::JID_CAP_DR;
			jid_pkg::JID_CAP_DR: tap_next = tms ? jid_pkg::JID_EX1_DR : jid_pkg::JID_SHF_DR;
			jid_pkg::JID_SHF_DR: tap_next = tms ? jid_pkg::JID_EX1_DR : jid_pkg::JID_SHF_DR;
			jid_pkg::JID_EX1_DR: tap_next = tms ? jid_pkg::JID_UPD_DR : jid_pkg::JID_PAU_DR;
			jid_pkg::JID_PAU_DR: tap_next = tms ? jid_pkg::JID_EX2_DR : jid_pkg::JID_PAU_DR;
			jid_pkg::JID_EX2_DR: tap_next = tms ? jid_pkg::JID_UPD_DR : jid_pkg::JID_SHF_DR;
			jid_pkg::JID_UPD_DR: tap_next = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_TAP_IDLE;
			jid_pkg::JID_SEL_IR: tap_next = tms ? jid_pkg::JID_TAP_RESET : jid_pkg::JID_CAP_IR;
			jid_pkg::JID_CAP_IR: tap_next = tms ? jid_pkg::JID_EX1_IR : jid_pkg::JID_SHF_IR;
			jid_pkg::JID_SHF_IR: tap_next = tms ? jid_pkg::JID_EX1_IR : jid_pkg::JID_SHF_IR;
			jid_pkg::JID_EX1_IR: tap_next = tms ? jid_pkg::JID_UPD_IR : jid_pkg::JID_PAU_IR;
			jid_pkg::JID_PAU_IR: tap_next = tms ? jid_pkg::JID_EX2_IR : jid_pkg::JID_PAU_IR;
			jid_pkg::JID_EX2_IR: tap_next = tms ? jid_pkg::JID_UPD_IR : jid_pkg::JID_SHF_IR;
			jid_pkg::JID_UPD_IR: tap_next = tms ? jid_pkg::JID_SEL_DR : jid_pkg::JID_TAP_IDLE;
			default: tap_next = jid_pkg::JID_TAP_RESET;
		endcase
	endfunction

	// Data path length chosen by an instruction
	function automatic logic [1:0] dr_sel(input logic [`JID_IR_W-1:0] op);
		case (op)
			`JID_OP_DEVICE_IDENTITY_WORD,
			`JID_OP_BOARD_TAG_WORD: dr_sel = `JID_SEL_WORD;
			`JID_OP_ADDR_LOAD,
			`JID_OP_MEM_FETCH,
			`JID_OP_MEM_STORE: dr_sel = `JID_SEL_BYTE;
			default: dr_sel = `JID_SEL_BYPASS;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Declarations

	logic [`JID_SYNC_W-1:0] sync1_reg;
	logic [`JID_SYNC_W-1:0] sync2_reg;
	logic tck_d_reg;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;
	jid_pkg::jid_tap_state_t state_reg;
	logic [`JID_IR_W-1:0] ir_sh_reg;
	logic [`JID_WORD_W-1:0] dr_sh_reg;
	logic [`JID_WORD_W-1:0] dr_sh_next;
	logic [1:0] sel;
	logic [`JID_WORD_W-1:0] id_word;
	logic [`JID_WORD_W-1:0] user_word;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edges are found on the second stage only

	// The test clock is far slower than ours, so sampling it is safe
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			tck_d_reg <= 1'h0;
		end
		else
		begin
			sync1_reg <= {tdi_i, tms_i, tck_i};
			sync2_reg <= sync1_reg;
			tck_d_reg <= sync2_reg[0];
		end
	end

	// Edge strobes and aligned pin levels
	assign tck_rise = sync2_reg[0] & ~tck_d_reg;
	assign tck_fall = ~sync2_reg[0] & tck_d_reg;
	assign tms_s = sync2_reg[1];
	assign tdi_s = sync2_reg[2];

	////////////////////////////////////////////////////////////////////
	// Controller state

	// Five highs on mode select walk any state into reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_reg <= jid_pkg::JID_TAP_RESET;
		else if (tck_rise)
			state_reg <= tap_next(state_reg, tms_s);
	end

	////////////////////////////////////////////////////////////////////
	// Instruction register

	// Shift stage: capture a fixed pattern, then shift toward data out
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ir_sh_reg <= `JID_IR_CAPTURE;
		else if (tck_rise)
		begin
			case (state_reg)
				jid_pkg::JID_CAP_IR: ir_sh_reg <= `JID_IR_CAPTURE;
				jid_pkg::JID_SHF_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[`JID_IR_W-1:1]};
				default: ir_sh_reg <= ir_sh_reg;
			endcase
		end
	end

	// Parallel stage; reset wins so the port always wakes on identity
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			instr_o <= `JID_OP_DEVICE_IDENTITY_WORD;
		else if (state_reg == jid_pkg::JID_TAP_RESET)
			instr_o <= `JID_OP_DEVICE_IDENTITY_WORD;
		else if (tck_fall && state_reg == jid_pkg::JID_UPD_IR)
			instr_o <= ir_sh_reg;
	end

	////////////////////////////////////////////////////////////////////
	// Actions taken when an instruction is latched

	// One-cycle pulses for restart and fault log, levels for the pages
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			soft_restart_o <= 1'h0;
			fault_snapshot_o <= 1'h0;
			fault_sel_o <= 2'h0;
			ext_page_o <= 1'h0;
			nvm_page_o <= 1'h0;
		end
		else
		begin
			soft_restart_o <= 1'h0;
			fault_snapshot_o <= 1'h0;
			if (tck_fall && state_reg == jid_pkg::JID_UPD_IR)
			begin
				case (ir_sh_reg)
					`JID_OP_RESTART: soft_restart_o <= 1'h1;
					`JID_OP_SNAPSHOT:
					begin
						fault_snapshot_o <= 1'h1;
						fault_sel_o <= fault_log_ctrl_i;
					end
					`JID_OP_EXT_ON: ext_page_o <= 1'h1;
					`JID_OP_EXT_OFF: ext_page_o <= 1'h0;
					`JID_OP_NVM_ON: nvm_page_o <= 1'h1;
					`JID_OP_NVM_OFF: nvm_page_o <= 1'h0;
					default: fault_sel_o <= fault_sel_o;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data registers

	// Words presented at capture
	assign id_word = {VERSION_ID, PART_ID, MAKER_ID, `JID_ID_FIXED};
	assign user_word = {{`JID_USER_PAD_W{1'b0}}, slave_addr_i, firmware_tag_i};
	assign sel = dr_sel(instr_o);

	// Shift one place; data in enters at the top of the selected length
	always_comb
	begin
		case (sel)
			`JID_SEL_WORD: dr_sh_next = {tdi_s, dr_sh_reg[`JID_WORD_W-1:1]};
			`JID_SEL_BYTE: dr_sh_next = {24'h0, tdi_s, dr_sh_reg[`JID_BYTE_W-1:1]};
			default: dr_sh_next = {31'h0, tdi_s};
		endcase
	end

	// One shared shift path serves every data register
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dr_sh_reg <= 32'h0;
		else if (tck_rise)
		begin
			case (state_reg)
				jid_pkg::JID_CAP_DR:
				begin
					case (instr_o)
						`JID_OP_DEVICE_IDENTITY_WORD: dr_sh_reg <= id_word;
						`JID_OP_BOARD_TAG_WORD: dr_sh_reg <= user_word;
						`JID_OP_ADDR_LOAD: dr_sh_reg <= {24'h0, mem_addr_o};
						`JID_OP_MEM_FETCH: dr_sh_reg <= {24'h0, mem_rdata_i};
						default: dr_sh_reg <= 32'h0;
					endcase
				end
				jid_pkg::JID_SHF_DR: dr_sh_reg <= dr_sh_next;
				default: dr_sh_reg <= dr_sh_reg;
			endcase
		end
	end

	// A read capture consumes the byte, letting memory advance the pointer
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mem_read_o <= 1'h0;
		else
			mem_read_o <= tck_rise && state_reg == jid_pkg::JID_CAP_DR
				&& instr_o == `JID_OP_MEM_FETCH;
	end

	// Output latches move only on the update falling edge
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_addr_o <= 8'h0;
			mem_addr_load_o <= 1'h0;
			mem_wdata_o <= 8'h0;
			mem_write_o <= 1'h0;
		end
		else
		begin
			mem_addr_load_o <= 1'h0;
			mem_write_o <= 1'h0;
			if (tck_fall && state_reg == jid_pkg::JID_UPD_DR)
			begin
				if (instr_o == `JID_OP_ADDR_LOAD)
				begin
					mem_addr_o <= dr_sh_reg[`JID_BYTE_W-1:0];
					mem_addr_load_o <= 1'h1;
				end
				if (instr_o == `JID_OP_MEM_STORE)
				begin
					mem_wdata_o <= dr_sh_reg[`JID_BYTE_W-1:0];
					mem_write_o <= 1'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial data out

	// Changes on the falling edge so the host samples a settled bit
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tdo_o <= 1'h0;
			tdo_oe_o <= 1'h0;
		end
		else if (tck_fall)
		begin
			case (state_reg)
				jid_pkg::JID_SHF_IR:
				begin
					tdo_o <= ir_sh_reg[0];
					tdo_oe_o <= 1'h1;
				end
				jid_pkg::JID_SHF_DR:
				begin
					tdo_o <= dr_sh_reg[0];
					tdo_oe_o <= 1'h1;
				end
				default:
				begin
					tdo_o <= tdo_o;
					tdo_oe_o <= 1'h0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== verification/jid_decoder_sva.sv ====
// Checker of the decoder's outputs against its inputs
`timescale 1ns/10ps
`default_nettype none
module jid_decoder_sva (
	// Clock, reset and link clock
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic tck_i,
	// Outputs watched
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire logic mem_read_o,
	input wire logic [4:0] instr_o,
	input wire logic [7:0] mem_addr_o,
	input wire logic mem_addr_load_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic mem_write_o,
	input wire logic soft_restart_o,
	input wire logic fault_snapshot_o,
	input wire logic ext_page_o,
	input wire logic nvm_page_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////
	// Action pulses last one cycle and follow their opcode
	sequence restart_s;
		instr_o == 5'h07 ##1 !soft_restart_o;
	endsequence
	sequence snap_s;
		instr_o == 5'h08 ##1 !fault_snapshot_o;
	endsequence
	restart_pulse_a: assert property (soft_restart_o |-> restart_s)
		else $error("restart pulse wrong");
	snap_pulse_a: assert property (fault_snapshot_o |-> snap_s)
		else $error("snapshot pulse wrong");
	// Parallel data moves only at an update, while the link clock is low
	addr_load_a: assert property (mem_addr_load_o |-> instr_o == 5'h04 && !tck_i)
		else $error("address load wrong");
	addr_hold_a: assert property ($changed(mem_addr_o) |-> mem_addr_load_o)
		else $error("address moved");
	wdata_hold_a: assert property ($changed(mem_wdata_o) |-> mem_write_o && instr_o == 5'h06)
		else $error("write data moved");
	tdo_fall_a: assert property ($changed(tdo_o) |-> !tck_i)
		else $error("tdo moved on high clock");
	oe_fall_a: assert property ($changed(tdo_oe_o) |-> !tck_i)
		else $error("tdo enable moved on high clock");
	// A fetch capture marks one cycle only, under the fetch opcode
	read_pulse_a: assert property (mem_read_o |-> instr_o == 5'h05 ##1 !mem_read_o)
		else $error("read pulse wrong");
	// Page levels follow their set and clear opcodes
	ext_page_a: assert property ($changed(ext_page_o) |-> instr_o == (ext_page_o ? 5'h09 : 5'h0a))
		else $error("ext page wrong");
	nvm_page_a: assert property ($changed(nvm_page_o) |-> instr_o == (nvm_page_o ? 5'h0b : 5'h0c))
		else $error("nvm page wrong");
endmodule
bind jid_decoder jid_decoder_sva i_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i),
	.tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .mem_read_o(mem_read_o),
	.instr_o(instr_o), .mem_addr_o(mem_addr_o), .mem_addr_load_o(mem_addr_load_o),
	.mem_wdata_o(mem_wdata_o), .mem_write_o(mem_write_o), .soft_restart_o(soft_restart_o),
	.fault_snapshot_o(fault_snapshot_o), .ext_page_o(ext_page_o), .nvm_page_o(nvm_page_o));
`default_nettype wire

// ==== verification/jid_host_model.sv ====
// Host adapter model: drives link clock, mode and data pins
`timescale 1ns/10ps
`default_nettype none
module jid_host_model (
	// Clock
	input wire logic ref_clk_i,
	// Link pins
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	// Bits taken in the data pulses of the last scan, and the raw shift of every rise
	logic [31:0] dout;
	logic [31:0] sh;
	// Link clock parked low outside frames
	initial
	begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
	end
	// One 125 ns link clock: pins change a cycle after the fall, tdo taken at the rise
	task automatic pulse(input logic tms, input logic tdi);
		@(posedge ref_clk_i);
		#1 tms_o = tms;
		tdi_o = tdi;
		repeat (11) @(posedge ref_clk_i);
		#1 tck_o = 1'h1;
		sh = {tdo_i, sh[31:1]};
		repeat (13) @(posedge ref_clk_i);
		#1 tck_o = 1'h0;
	endtask
	// Five high mode rises reach reset from anywhere, then park in idle
	task automatic tlr();
		repeat (5) pulse(1'h1, 1'h0);
		pulse(1'h0, 1'h0);
	endtask
	// From idle, one scan of n bits LSB first, back to idle; sole memory path
	task automatic scan(input logic ir, input int n, input logic [31:0] din);
		pulse(1'h1, 1'h0);
		if (ir)
			pulse(1'h1, 1'h0);
		pulse(1'h0, 1'h0);
		pulse(1'h0, 1'h0);
		for (int i = 0; i < n; i++)
			pulse(i == n - 1, din[i]);
		// Walk-in and walk-out rises must not pollute the scanned bits
		dout = sh;
		pulse(1'h1, 1'h0);
		pulse(1'h0, 1'h0);
	endtask
endmodule
`default_nettype wire

// ==== verification/jid_decoder_tb_top.sv ====
// Self-checking bench of the test-port instruction decoder
`timescale 1ns/10ps
`default_nettype none
module jid_decoder_tb_top;
	// Identity fields, values arbitrary
	localparam logic [10:0] MAKER = 11'h155;
	localparam logic [15:0] PART = 16'h0c3a;
	localparam logic [3:0] VER = 4'h5;
	logic clk, rst_n, tck, tms, tdi, tdo, oe, mload, mread, mwrite, rst_p, snap, ext, nvm;
	logic [7:0] tag, rdata, maddr, wdata, rnd, m_addr;
	logic [6:0] saddr;
	logic [4:0] instr;
	logic [1:0] flog, fsel;
	logic [31:0] got;
	logic [4:0] byp[$] = '{5'h1f, 5'h15, 5'h02};
	logic [4:0] pages[$] = '{5'h09, 5'h0b, 5'h0a, 5'h0c};
	int fail_count, num_checks, n_restart, n_snap, n_read, m_ext, m_nvm, n_oe;
	////////////////////////////////
	// 200 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	jid_decoder #(.MAKER_ID(MAKER), .PART_ID(PART), .VERSION_ID(VER)) i_dut (
		.ref_clk_i(clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(oe), .firmware_tag_i(tag), .slave_addr_i(saddr),
		.mem_rdata_i(rdata), .fault_log_ctrl_i(flog), .instr_o(instr), .mem_addr_o(maddr),
		.mem_addr_load_o(mload), .mem_read_o(mread), .mem_wdata_o(wdata),
		.mem_write_o(mwrite), .soft_restart_o(rst_p), .fault_snapshot_o(snap),
		.fault_sel_o(fsel), .ext_page_o(ext), .nvm_page_o(nvm));
	jid_host_model i_host (.ref_clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
	// Count the action pulses the design fires
	always @(posedge clk)
	begin
		n_restart += rst_p;
		n_snap += snap;
		n_read += mread;
	end
	// Count link rises at which the data out driver is enabled
	always @(posedge tck)
		n_oe += oe;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic dr(input int n, input logic [31:0] din);
		n_oe = 0;
		i_host.scan(1'h0, n, din);
		repeat (8) @(posedge clk);
		got = i_host.dout >> (32 - n);
		check("oe_dr", n_oe, n);
	endtask
	task automatic load_ir(input logic [4:0] op);
		n_oe = 0;
		i_host.scan(1'h1, 5, {27'h0, op});
		repeat (8) @(posedge clk);
		check("ir_capture", i_host.dout >> 27, 32'h1);
		check("instr", {27'h0, instr}, {27'h0, op});
		check("oe_ir", n_oe, 5);
	endtask
	task automatic set_addr(input logic [7:0] a);
		load_ir(5'h04);
		dr(8, {24'h0, a});
		check("addr_capture", got, {24'h0, m_addr});
		check("addr", {24'h0, maddr}, {24'h0, a});
		m_addr = a;
	endtask
	task automatic read_mem();
		#1 rdata = rnd;
		rnd = lfsr(rnd);
		load_ir(5'h05);
		dr(8, 32'h0);
		check("rdata", got, {24'h0, rdata});
	endtask
	// Main sequence
	initial
	begin
		rst_n = 1'h0;
		tag = 8'h0;
		saddr = 7'h0;
		rdata = 8'h0;
		flog = 2'h0;
		rnd = 8'h40;
		m_addr = 8'h0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (4) @(posedge clk);
		check("instr_reset", {27'h0, instr}, 32'h0);
		i_host.tlr();
		dr(32, 32'h0);
		check("device_identity_word", got, {VER, PART, MAKER, 1'h1});
		#1 tag = rnd;
		rnd = lfsr(rnd);
		saddr = rnd[6:0];
		rnd = lfsr(rnd);
		load_ir(5'h03);
		dr(32, 32'h0);
		check("board_tag_word", got, {17'h0, saddr, tag});
		foreach (byp[i])
		begin
			load_ir(byp[i]);
			dr(8, {24'h0, rnd});
			check("bypass", got, {24'h0, rnd[6:0], 1'h0});
			rnd = lfsr(rnd);
		end
		foreach (pages[i])
		begin
			load_ir(pages[i]);
			m_ext = pages[i] == 5'h09 ? 1 : pages[i] == 5'h0a ? 0 : m_ext;
			m_nvm = pages[i] == 5'h0b ? 1 : pages[i] == 5'h0c ? 0 : m_nvm;
			check("ext_page", {31'h0, ext}, m_ext);
			check("nvm_page", {31'h0, nvm}, m_nvm);
			if (pages[i] == 5'h0b)
			begin
				set_addr(rnd);
				read_mem();
				set_addr(m_addr);
				read_mem();
			end
		end
		load_ir(5'h06);
		dr(8, {24'h0, rnd});
		check("wdata", {24'h0, wdata}, {24'h0, rnd});
		load_ir(5'h07);
		check("restarts", n_restart, 1);
		#1 flog = rnd[1:0];
		load_ir(5'h08);
		check("snapshots", n_snap, 1);
		check("fault_sel", {30'h0, fsel}, {30'h0, flog});
		check("reads", n_read, 2);
		// Start an instruction scan; the reset walk leaves shift-IR through update-IR, latching 08h
		repeat (2) i_host.pulse(1'h1, 1'h0);
		repeat (3) i_host.pulse(1'h0, 1'h1);
		i_host.tlr();
		repeat (8) @(posedge clk);
		check("instr_tlr", {27'h0, instr}, 32'h0);
		check("ext_kept", {31'h0, ext}, m_ext);
		end_of_test();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
